// ===== shared/ats_sec_pkg.sv
// shared constants and carrier types for the translation-service policy block
package ats_sec_pkg;
    // ======================================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int SID_W = 3;
    localparam int ENTRIES = 16;
    // ======================================================================
    // register byte offsets
    localparam logic [7:0] OFF_ID_ZERO = 8'h00;
    localparam logic [7:0] OFF_CONTROL_ZERO = 8'h04;
    localparam logic [7:0] OFF_BYPASS_ATTR = 8'h08;
    localparam logic [7:0] OFF_ENTRY_SELECT = 8'h0C;
    localparam logic [7:0] OFF_ENTRY_DATA = 8'h10;
    localparam logic [7:0] OFF_ENTRY_INVAL = 8'h14;
    localparam logic [7:0] OFF_INVAL_STATUS = 8'h18;
    localparam logic [7:0] OFF_SEC_ID_ONE = 8'h40;
    localparam logic [7:0] OFF_SEC_CONTROL_ZERO = 8'h44;
    localparam logic [7:0] OFF_SEC_BYPASS_ATTR = 8'h48;
    localparam logic [7:0] OFF_SEC_INIT = 8'h4C;
    // ======================================================================
    // field positions
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_CHECK_EN = 1;
    localparam int BIT_BYPASS_ABORT = 0;
    localparam int BIT_ID_ATS = 0;
    localparam int BIT_ID_STAGE1 = 1;
    localparam int BIT_SEC_IMPL = 0;
    localparam int BIT_ENTRY_VALID = 0;
    localparam int BIT_ENTRY_MODE = 1;
    localparam int BIT_SELECT_SECURE = 8;
    localparam int BIT_INIT_INVAL_ALL = 0;
    localparam int BIT_INVAL_ERROR = 0;
    localparam int BIT_INVAL_UR = 1;
    // ======================================================================
    // reset values and mode encodings
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] MODE_OFF = 2'b00;
    localparam logic [1:0] MODE_FULL = 2'b01;
    localparam logic [1:0] MODE_SPLIT = 2'b10;
    // ======================================================================
    // endpoint invalidation outcome codes
    typedef enum logic [1:0] {
        INV_OK = 2'b00,
        INV_UR = 2'b01,
        INV_FAIL = 2'b10
    } inval_status_type;
    // incoming transaction or translation request
    typedef struct packed {
        logic valid;
        logic [SID_W-1:0] stream_id;
        logic secure_stream_flag;
        logic translated;
        logic cxl_cache;
        logic ats_request;
        logic source_cxl;
        logic wb_shareable;
        logic in_world_attr;
        logic table_world_attr;
    } txn_in_type;
    // registered verdict
    typedef struct packed {
        logic valid;
        logic abort;
        logic security_world_attribute;
        logic cxl_io;
        logic secure_stream;
    } txn_out_type;
    // endpoint invalidation outcome
    typedef struct packed {
        logic done;
        inval_status_type status;
    } inval_in_type;
endpackage : ats_sec_pkg

// ===== core/ats_sec_policy.sv
// translated-traffic policy and security state selection with its APB registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// What this block does
// - endpoint invalidate answered Unsupported Request completes without any error.
// - check enable is cached per entry; entries must be invalidated to see change.
// - with check enable clear, split mode is treated as disabled.
// - entries fetched after a check enable update use the new value.
// - with check enable set, translated traffic to a mode-off entry is terminated.
// - with check enable clear and global enable set, non-secure translated traffic passes without configuration checks.
// - translation services are implemented and the supported flag reads one.
// - translated cache-protocol traffic is not checked against the service mode.
// - source-cxl request on split-mode stream gets the io bit set.
// - source-cxl request with non write-back shareable memory gets the io bit.
// - single state: secure registers read zero, only non-secure output.
// - two states: secure table present, stage one supported, both attributes possible.
// - secure registers except init answer secure accesses only; else read zero.
// - secure streams use secure table, bypass and enable; others non-secure ones.
// - non-secure streams and translated traffic leave non-secure; other secure streams follow table or input.
// - secure stream flag one selects the secure table, zero the non-secure table.
module ats_sec_policy
    import ats_sec_pkg::*;
#(
    parameter bit TWO_STATES = 1'b1,
    parameter bit STAGE1_SINGLE = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire txn_in_type txn_in,
    output txn_out_type txn_out,
    input wire inval_in_type inval_in,
    output logic inval_complete,
    output logic inval_error
);
    // ======================================================================
    // APB front end
    logic setup;
    logic wr_setup;
    logic sec_access;
    logic [31:0] rdata_d;
    logic err_d;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [31:0] control_q;
    logic [31:0] bypass_q;
    logic [31:0] sec_control_q;
    logic [31:0] sec_bypass_q;
    logic [31:0] select_q;
    logic [1:0] inval_status_q;
    logic inval_complete_q;
    logic inval_error_q;
    logic [ENTRIES-1:0] entry_valid_q;
    logic [1:0] entry_mode_q [ENTRIES];
    logic [ENTRIES-1:0] entry_chk_q;
    logic [3:0] sel_idx;
    logic sel_secure;
    logic sel_ok;
    logic entry_wr;
    logic entry_inv;
    logic inv_all;
    txn_out_type txn_out_q;

    // decoding every register shares: is this address a secure register
    function automatic logic is_secure_reg(input logic [ADDR_W-1:0] a);
        is_secure_reg = (a == OFF_SEC_ID_ONE) || (a == OFF_SEC_CONTROL_ZERO) ||
                        (a == OFF_SEC_BYPASS_ATTR);
    endfunction : is_secure_reg

    // decode happens in setup so read data can come from a flop with zero waits
    assign setup = psel && !penable;
    assign wr_setup = setup && pwrite;
    assign sec_access = TWO_STATES && !pprot[1];
    assign sel_idx = {select_q[BIT_SELECT_SECURE], select_q[SID_W-1:0]};
    assign sel_secure = select_q[BIT_SELECT_SECURE];
    assign sel_ok = !sel_secure || sec_access;
    assign entry_wr = wr_setup && paddr == OFF_ENTRY_DATA && sel_ok;
    assign entry_inv = wr_setup && paddr == OFF_ENTRY_INVAL && sel_ok;
    assign inv_all = wr_setup && paddr == OFF_SEC_INIT && TWO_STATES &&
                     pwdata[BIT_INIT_INVAL_ALL];

    // read mux; secure registers read zero to non-secure or single-state access
    always_comb begin
        rdata_d = RST_WORD;
        err_d = 1'b0;
        if (paddr == OFF_ID_ZERO) begin
            rdata_d[BIT_ID_ATS] = 1'b1;
            rdata_d[BIT_ID_STAGE1] = TWO_STATES || STAGE1_SINGLE;
        end else if (paddr == OFF_CONTROL_ZERO) begin
            rdata_d = control_q;
        end else if (paddr == OFF_BYPASS_ATTR) begin
            rdata_d = bypass_q;
        end else if (paddr == OFF_ENTRY_SELECT) begin
            rdata_d = select_q;
        end else if (paddr == OFF_ENTRY_DATA) begin
            if (sel_ok) begin
                rdata_d[BIT_ENTRY_VALID] = entry_valid_q[sel_idx];
                rdata_d[BIT_ENTRY_MODE +: 2] = entry_mode_q[sel_idx];
            end
        end else if (paddr == OFF_ENTRY_INVAL) begin
            rdata_d = RST_WORD;
        end else if (paddr == OFF_INVAL_STATUS) begin
            rdata_d[1:0] = inval_status_q;
        end else if (is_secure_reg(paddr) || paddr == OFF_SEC_INIT) begin
            if (sec_access && paddr == OFF_SEC_ID_ONE) begin
                rdata_d[BIT_SEC_IMPL] = 1'b1;
            end else if (sec_access && paddr == OFF_SEC_CONTROL_ZERO) begin
                rdata_d = sec_control_q;
            end else if (sec_access && paddr == OFF_SEC_BYPASS_ATTR) begin
                rdata_d = sec_bypass_q;
            end
        end else begin
            err_d = 1'b1;
        end
    end

    // response flops, loaded in setup and shown during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RST_WORD;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? RST_WORD : rdata_d;
            pslverr_q <= err_d;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // ======================================================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= RST_WORD;
            bypass_q <= RST_WORD;
            select_q <= RST_WORD;
        end else if (wr_setup) begin
            if (paddr == OFF_CONTROL_ZERO) begin
                control_q <= pwdata & 32'h0000_0003;
            end else if (paddr == OFF_BYPASS_ATTR) begin
                bypass_q <= pwdata & 32'h0000_0001;
            end else if (paddr == OFF_ENTRY_SELECT) begin
                select_q <= pwdata & 32'h0000_0107;
            end
        end
    end

    // secure copies ignore writes unless both states exist and the access is secure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_control_q <= RST_WORD;
            sec_bypass_q <= RST_WORD;
        end else if (wr_setup && sec_access) begin
            if (paddr == OFF_SEC_CONTROL_ZERO) begin
                sec_control_q <= pwdata & 32'h0000_0001;
            end else if (paddr == OFF_SEC_BYPASS_ATTR) begin
                sec_bypass_q <= pwdata & 32'h0000_0001;
            end
        end
    end

    // ======================================================================
    // stream tables: low half non-secure, high half secure
    // the check enable is latched at fetch (write) and at invalidation, so a
    // change of the check enable bit reaches an entry only once it is invalidated or rewritten
    for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                entry_valid_q[i] <= 1'b0;
                entry_mode_q[i] <= MODE_OFF;
                entry_chk_q[i] <= 1'b0;
            end else if (entry_wr && sel_idx == 4'(i)) begin
                entry_valid_q[i] <= pwdata[BIT_ENTRY_VALID];
                entry_mode_q[i] <= pwdata[BIT_ENTRY_MODE +: 2];
                entry_chk_q[i] <= control_q[BIT_CHECK_EN];
            end else if ((entry_inv && sel_idx == 4'(i)) || inv_all) begin
                entry_chk_q[i] <= control_q[BIT_CHECK_EN];
            end
        end
    end

    // ======================================================================
    // transaction policy
    logic secure_stream;
    logic [3:0] idx;
    logic global_en;
    logic bypass_abort;
    logic [1:0] eff_mode;
    logic entry_valid;
    txn_out_type txn_d;

    assign secure_stream = TWO_STATES && txn_in.secure_stream_flag;
    assign idx = {secure_stream, txn_in.stream_id};
    assign global_en = secure_stream ? sec_control_q[BIT_GLOBAL_EN]
                                     : control_q[BIT_GLOBAL_EN];
    assign bypass_abort = secure_stream ? sec_bypass_q[BIT_BYPASS_ABORT]
                                        : bypass_q[BIT_BYPASS_ABORT];
    assign entry_valid = entry_valid_q[idx];
    // split mode without the cached check reads as disabled
    assign eff_mode = (entry_mode_q[idx] == MODE_SPLIT && !entry_chk_q[idx]) ?
                      MODE_OFF : entry_mode_q[idx];

    // verdict is worked out every cycle; idle cycles carry valid low and are ignored
    always_comb begin
        txn_d = '0;
        txn_d.valid = txn_in.valid;
        txn_d.secure_stream = secure_stream;
        // non-secure streams always leave as non-secure
        txn_d.security_world_attribute = 1'b1;
        if (secure_stream) begin
            txn_d.security_world_attribute = global_en ? txn_in.table_world_attr
                                                       : txn_in.in_world_attr;
        end
        if (txn_in.translated) begin
            txn_d.security_world_attribute = 1'b1;
            if (secure_stream || !control_q[BIT_GLOBAL_EN]) begin
                txn_d.abort = 1'b1;
            end else if (!control_q[BIT_CHECK_EN]) begin
                txn_d.abort = 1'b0;
            end else if (txn_in.cxl_cache) begin
                txn_d.abort = 1'b0;
            end else begin
                txn_d.abort = !entry_valid || eff_mode == MODE_OFF;
            end
        end else if (txn_in.ats_request) begin
            txn_d.abort = !global_en || !entry_valid || eff_mode == MODE_OFF;
            txn_d.cxl_io = txn_in.source_cxl &&
                           (eff_mode == MODE_SPLIT || !txn_in.wb_shareable);
        end else begin
            txn_d.abort = global_en ? !entry_valid : bypass_abort;
        end
    end

    // verdict is registered: one cycle from request to answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txn_out_q <= '0;
        end else begin
            txn_out_q <= txn_d;
        end
    end

    assign txn_out = txn_out_q;

    // ======================================================================
    // endpoint invalidation outcome; UR completes cleanly though nothing may be done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inval_complete_q <= 1'b0;
            inval_error_q <= 1'b0;
            inval_status_q <= 2'b00;
        end else begin
            inval_complete_q <= inval_in.done;
            inval_error_q <= inval_in.done && inval_in.status == INV_FAIL;
            if (inval_in.done) begin
                inval_status_q[BIT_INVAL_ERROR] <= inval_in.status == INV_FAIL;
                inval_status_q[BIT_INVAL_UR] <= inval_in.status == INV_UR;
            end
        end
    end

    assign inval_complete = inval_complete_q;
    assign inval_error = inval_error_q;

    // ======================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ur_no_error: assert property (inval_in.done && inval_in.status == INV_UR |=>
        inval_complete && !inval_error) else $error("ur invalidate raised an error");
    // translated traffic, endpoint caches and completion marking
    chk_split_disabled: assert property (txn_in.valid && txn_in.translated &&
        control_q[BIT_GLOBAL_EN] && control_q[BIT_CHECK_EN] && !txn_in.cxl_cache &&
        !secure_stream && entry_mode_q[idx] == MODE_SPLIT && !entry_chk_q[idx] |=> txn_out.abort)
        else $error("split mode without check not treated as off");
    chk_chk_latched: assert property (entry_inv && !entry_wr |=>
        entry_chk_q[$past(sel_idx)] == $past(control_q[BIT_CHECK_EN]))
        else $error("invalidate did not take new check value");
    chk_fetch_new_chk: assert property (entry_wr |=>
        entry_chk_q[$past(sel_idx)] == $past(control_q[BIT_CHECK_EN]))
        else $error("fetched entry used stale check value");
    chk_off_terminated: assert property (txn_in.valid && txn_in.translated &&
        !secure_stream && control_q[1:0] == 2'b11 && !txn_in.cxl_cache &&
        eff_mode == MODE_OFF |=> txn_out.valid && txn_out.abort)
        else $error("translated traffic to off entry passed");
    chk_no_check_pass: assert property (txn_in.valid && txn_in.translated &&
        !secure_stream && control_q[1:0] == 2'b01 |=> !txn_out.abort)
        else $error("unchecked translated traffic aborted");
    chk_cxl_skip: assert property (txn_in.translated && txn_in.cxl_cache &&
        !secure_stream && control_q[BIT_GLOBAL_EN] |=> !txn_out.abort)
        else $error("cache traffic checked");
    chk_io_split: assert property (txn_in.ats_request && !txn_in.translated &&
        txn_in.source_cxl && eff_mode == MODE_SPLIT |=> txn_out.cxl_io)
        else $error("io bit missing on split stream");
    chk_io_memtype: assert property (txn_in.ats_request && !txn_in.translated &&
        txn_in.source_cxl && !txn_in.wb_shareable |=> txn_out.cxl_io)
        else $error("io bit missing for non write-back memory");
    chk_ns_only: assert property (txn_out.valid && !txn_out.secure_stream |->
        txn_out.security_world_attribute) else $error("non-secure stream left secure");
    chk_sec_raz: assert property (setup && !pwrite && is_secure_reg(paddr) &&
        !sec_access |=> prdata == RST_WORD) else $error("secure register visible to non-secure");
    chk_flag_index: assert property (txn_in.valid |=>
        txn_out.secure_stream == $past(TWO_STATES && txn_in.secure_stream_flag))
        else $error("stream table chosen wrongly");
    chk_ats_flag: assert property (setup && !pwrite && paddr == OFF_ID_ZERO |=>
        prdata[BIT_ID_ATS]) else $error("ats flag not set");
    // secure interface: refused writes and bypass attributes; invalidation completion only after an endpoint answer
    chk_sec_wi: assert property (wr_setup && !sec_access |=>
        $stable(sec_control_q) && $stable(sec_bypass_q))
        else $error("non-secure write reached a secure register");
    chk_sec_bypass: assert property (txn_in.valid && secure_stream &&
        !txn_in.translated && !txn_in.ats_request && !sec_control_q[BIT_GLOBAL_EN] |=>
        txn_out.abort == $past(sec_bypass_q[BIT_BYPASS_ABORT]))
        else $error("secure bypass attribute not used");
    chk_sec_ns_input: assert property (txn_in.valid && secure_stream && !global_en &&
        !txn_in.translated |=> txn_out.security_world_attribute == $past(txn_in.in_world_attr))
        else $error("secure bypass ignored the incoming attribute");
    chk_done_pulse: assert property (!inval_in.done |=> !inval_complete && !inval_error)
        else $error("invalidation completion without an endpoint answer");

    cov_split_io: cover property (txn_in.ats_request && txn_in.source_cxl &&
        eff_mode == MODE_SPLIT);
    cov_sec_bypass: cover property (txn_in.valid && secure_stream && !global_en);
    cov_secure_txn: cover property (txn_out.valid && txn_out.secure_stream);
    cov_ur_done: cover property (inval_in.done && inval_in.status == INV_UR);
    cov_term: cover property (txn_out.valid && txn_out.abort);
endmodule : ats_sec_policy

// ===== bench/ats_endpoint_model.sv
// endpoint model: issues requests and answers invalidations
`timescale 1ns/100ps
module ats_endpoint_model
    import ats_sec_pkg::*;
(
    input wire logic pclk,
    output txn_in_type txn_in,
    output inval_in_type inval_in
);
    // ======================================================================
    // idle lines at time zero
    initial begin
        txn_in = '0;
        inval_in = '0;
    end
    // one request per call; released fields are inverted so stale data never looks right
    task automatic issue(input txn_in_type t);
        @(posedge pclk);
        txn_in <= t;
        @(posedge pclk);
        txn_in <= txn_in_type'({1'b0, ~t[$bits(txn_in_type)-2:0]});
    endtask : issue
    // an unsupported-request reply is a legal endpoint answer, not a fault
    task automatic answer(input inval_status_type st);
        @(posedge pclk);
        inval_in <= '{done: 1'b1, status: st};
        @(posedge pclk);
        inval_in <= '{done: 1'b0, status: inval_status_type'(~st)};
    endtask : answer
endmodule : ats_endpoint_model

// ===== bench/test_ats_sec_policy.sv
// self-checking bench for the translation policy block
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ats_sec_policy
    import ats_sec_pkg::*;
;
    localparam logic [2:0] SEC = 3'b000;
    localparam logic [2:0] NSEC = 3'b010;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0] pprot = '0;
    logic pready, pslverr, inval_complete, inval_error, err;
    txn_in_type txn_in;
    txn_out_type txn_out;
    inval_in_type inval_in;
    int error_cnt = 0, n_compared = 0;
    // shadow of programmed state: entry is {mode, valid}
    logic ge = 0, chk = 0, sge = 0, nbyp = 0, sbyp = 0;
    logic [2:0] ent [2][8];
    logic lchk [2][8];
    always #20 pclk = ~pclk;
    ats_sec_policy #(.TWO_STATES(1'b1), .STAGE1_SINGLE(1'b0)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .txn_in(txn_in), .txn_out(txn_out), .inval_in(inval_in),
        .inval_complete(inval_complete), .inval_error(inval_error));
    ats_endpoint_model ep (.pclk(pclk), .txn_in(txn_in), .inval_in(inval_in));
    // ======================================================================
    // closing report
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // one apb transfer; waits on pready with a bound instead of assuming zero wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [2:0] pr);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pprot <= pr;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [2:0] pr, input logic [31:0] e,
                         input logic ee);
        apb(0, a, 32'h0000_0000, pr);
        `CHK(err, ee)
        if (!ee) `CHK(rd, e)
    endtask : rdchk
    task automatic sel(input logic s, input logic [2:0] id);
        apb(1, OFF_ENTRY_SELECT, {23'h0, s, 5'h0, id}, SEC);
    endtask : sel
    // entry write is a fetch, so it latches the current check enable
    task automatic set_entry(input logic s, input logic [2:0] id, input logic v,
                             input logic [1:0] m);
        if (m != MODE_OFF && ent[s][id][2:1] != MODE_OFF && ent[s][id][2:1] != m)
            set_entry(s, id, ent[s][id][0], MODE_OFF);
        sel(s, id);
        apb(1, OFF_ENTRY_DATA, {29'h0, m, v}, SEC);
        ent[s][id] = {m, v};
        lchk[s][id] = chk;
    endtask : set_entry
    task automatic inval_entry(input logic s, input logic [2:0] id);
        sel(s, id);
        apb(1, OFF_ENTRY_INVAL, 32'h0000_0000, SEC);
        lchk[s][id] = chk;
    endtask : inval_entry
    // split entries are retired before the check is cleared
    task automatic set_ctl(input logic g, input logic c);
        if (chk && !c) foreach (ent[i, j])
            if (ent[i][j][2:1] == MODE_SPLIT)
                set_entry(1'(i), 3'(j), ent[i][j][0], MODE_OFF);
        apb(1, OFF_CONTROL_ZERO, {30'h0, c, g}, SEC);
        ge = g;
        chk = c;
    endtask : set_ctl
    // expected verdict from the shadow state
    function automatic txn_out_type expv(input txn_in_type t);
        txn_out_type o;
        logic s, en;
        logic [2:0] e;
        logic [1:0] m;
        s = t.secure_stream_flag;
        e = ent[s][t.stream_id];
        en = s ? sge : ge;
        m = (e[2:1] == MODE_SPLIT && !lchk[s][t.stream_id]) ? MODE_OFF : e[2:1];
        o = '0;
        o.valid = 1;
        o.secure_stream = s;
        o.security_world_attribute = 1;
        if (t.translated) o.abort = s | !ge | (chk & !t.cxl_cache & (!e[0] | m == MODE_OFF));
        else if (t.ats_request) begin
            o.abort = !en | !e[0] | m == MODE_OFF;
            o.cxl_io = t.source_cxl & (m == MODE_SPLIT | !t.wb_shareable);
        end else begin
            o.abort = en ? !e[0] : (s ? sbyp : nbyp);
            if (s) o.security_world_attribute = en ? t.table_world_attr : t.in_world_attr;
        end
        return o;
    endfunction : expv
    // f is {cxl_cache, source_cxl, wb_shareable, in_world, table_world}
    function automatic txn_in_type mk(input logic s, input logic [2:0] id,
                                      input logic [1:0] k, input logic [4:0] f);
        return txn_in_type'({1'b1, id, s, k == 2'd1, f[4], k == 2'd2, f[3:0]});
    endfunction : mk
    task automatic send(input txn_in_type t);
        txn_out_type o;
        ep.issue(t);
        #1;
        o = expv(t);
        `CHK({txn_out.valid, txn_out.secure_stream}, {1'b1, o.secure_stream})
        `CHK(txn_out.abort, o.abort)
        if (t.ats_request) `CHK(txn_out.cxl_io, o.cxl_io)
        else `CHK(txn_out.security_world_attribute, o.security_world_attribute)
        @(posedge pclk);
        #1;
        `CHK(txn_out.valid, 1'b0)
    endtask : send
    // ======================================================================
    // main sequence
    initial begin
        logic [4:0] f;
        logic s;
        logic [2:0] id;
        foreach (ent[i, j]) begin
            ent[i][j] = '0;
            lchk[i][j] = 0;
        end
        void'($urandom(32'h48a4_31b8));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        rdchk(OFF_ID_ZERO, SEC, 32'h0000_0003, 0);
        rdchk(OFF_CONTROL_ZERO, SEC, RST_WORD, 0);
        rdchk(OFF_SEC_ID_ONE, SEC, 32'h0000_0001, 0);
        rdchk(OFF_SEC_ID_ONE, NSEC, RST_WORD, 0);
        rdchk(8'h20, SEC, RST_WORD, 1);
        apb(1, OFF_SEC_CONTROL_ZERO, 32'h0000_0001, NSEC);
        rdchk(OFF_SEC_CONTROL_ZERO, SEC, RST_WORD, 0);
        // every invalidation outcome; unsupported request is no error
        for (int k = 0; k < 3; k++) begin
            ep.answer(inval_status_type'(2'(k)));
            #1;
            `CHK({inval_complete, inval_error}, {1'b1, k == 2})
            rdchk(OFF_INVAL_STATUS, SEC, {30'h0, k == 1, k == 2}, 0);
        end
        // corners: cached check, split with check off, cache-protocol skip
        set_ctl(1, 0);
        set_entry(0, 3'd2, 1, MODE_SPLIT);
        send(mk(0, 3'd2, 2'd2, 5'h0C));
        set_ctl(1, 1);
        send(mk(0, 3'd2, 2'd2, 5'h0C));
        send(mk(0, 3'd2, 2'd1, 5'h00));
        inval_entry(0, 3'd2);
        send(mk(0, 3'd2, 2'd2, 5'h0C));
        set_entry(0, 3'd5, 1, MODE_OFF);
        send(mk(0, 3'd5, 2'd1, 5'h00));
        send(mk(0, 3'd5, 2'd1, 5'h10));
        set_entry(0, 3'd6, 1, MODE_FULL);
        send(mk(0, 3'd6, 2'd2, 5'h08));
        send(mk(1, 3'd1, 2'd0, 5'h01));
        send(mk(1, 3'd1, 2'd1, 5'h00));
        set_ctl(1, 0);
        send(mk(0, 3'd5, 2'd1, 5'h00));
        set_entry(1, 3'd1, 1, MODE_FULL);
        apb(1, OFF_SEC_CONTROL_ZERO, 32'h0000_0001, SEC);
        sge = 1;
        send(mk(1, 3'd1, 2'd0, 5'h02));
        send(mk(0, 3'd1, 2'd0, 5'h03));
        // random configuration and traffic
        repeat (60) begin
            case ($urandom_range(5))
                0: set_ctl(1'($urandom), 1'($urandom));
                1: set_entry(1'($urandom), 3'($urandom), 1'($urandom),
                             chk ? 2'($urandom_range(2)) : 2'($urandom_range(1)));
                2: inval_entry(1'($urandom), 3'($urandom));
                3: begin
                    {sbyp, nbyp} = 2'($urandom);
                    apb(1, OFF_BYPASS_ATTR, {31'h0, nbyp}, SEC);
                    apb(1, OFF_SEC_BYPASS_ATTR, {31'h0, sbyp}, SEC);
                end
                4: begin
                    sge = 1'($urandom);
                    apb(1, OFF_SEC_CONTROL_ZERO, {31'h0, sge}, SEC);
                end
                default: begin
                    apb(1, OFF_SEC_INIT, 32'h0000_0001, NSEC);
                    foreach (lchk[i, j]) lchk[i][j] = chk;
                end
            endcase
            repeat (4) begin
                s = 1'($urandom);
                id = 3'($urandom);
                f = 5'($urandom);
                if (ent[s][id][2:1] == MODE_SPLIT) f[4] = 0;
                send(mk(s, id, 2'($urandom_range(2)), f));
            end
        end
        conclude();
    end
endmodule : test_ats_sec_policy
